// File: rip_core_model.sv
// Core stand-in: takes one interrupt request per accept window.
// Assumes the bench raises i_accept and i_ret_cmd at the falling edge.
module rip_core_model import rip_pkg::*; (
	input wire logic i_clk,
	input wire logic i_accept,
	input wire logic i_ret_cmd,
	input wire rip_pkg::rip_irq_req_t i_req,
	output logic o_ack,
	output logic o_reti,
	output logic [15:0] o_taken_vec
);
	timeunit 1ns;
	timeprecision 1ps;
	logic taken_q = 1'b0;
	initial {o_ack, o_reti, o_taken_vec} = '0;
	// Ack only a standing valid request, once per window
	always @(posedge i_clk) begin
		o_ack <= i_accept && i_req.valid && !taken_q;
		taken_q <= i_accept && (taken_q || i_req.valid);
		o_reti <= i_ret_cmd;
		if (i_accept && i_req.valid && !taken_q)
			o_taken_vec <= i_req.vector;
	end
endmodule

// File: rip_pkg.sv
// Types for the reset and interrupt priority block.
// Assumes rip_regs.svh supplies the numeric constants.
package rip_pkg;
	typedef enum logic [3:0] {
		RIP_BOOT_RESET = 4'h1,
		RIP_BOOT_EMUL = 4'h2,
		RIP_BOOT_BAUD = 4'h4,
		RIP_BOOT_USER = 4'h8
	} rip_boot_t;
	// Sources in polling order: ext0, bod, t0, ext1, t1, cnta, ser, t2
	typedef struct packed {
		logic [7:0] flag;
		logic [7:0] enable;
		logic [7:0] prio_hi;
		logic [7:0] prio_lo;
	} rip_irq_cfg_t;
	typedef struct packed {
		logic valid;
		logic [2:0] src;
		logic [1:0] level;
		logic [15:0] vector;
	} rip_irq_req_t;
endpackage

// File: rip_regs.svh
// Constants for the reset and interrupt priority block.
// Assumes a 40 MHz oscillator clock.
`ifndef RIP_REGS_SVH
`define RIP_REGS_SVH
`define RIP_RESET_VEC 16'h0000
`define RIP_VEC_EXT0 16'h0003
`define RIP_VEC_TMR0 16'h000b
`define RIP_VEC_EXT1 16'h0013
`define RIP_VEC_TMR1 16'h001b
`define RIP_VEC_SER 16'h0023
`define RIP_VEC_TMR2 16'h002b
`define RIP_VEC_CNTA 16'h0033
`define RIP_VEC_BOD 16'h004b
`define RIP_CLK_MHZ 40
`define RIP_RST_MIN_CLKS 24
`define RIP_BOD_FILT_CLKS 4
`define RIP_AUTOBAUD_MS 400
`define RIP_AUTOBAUD_CYC (`RIP_AUTOBAUD_MS * 1000 * `RIP_CLK_MHZ)
`define RIP_SWR_BIT 1
`define RIP_BROWNOUT_EN_BIT 3
`define RIP_NSRC 8
`endif

// File: rip_top.sv
// Reset sequencing and interrupt priority logic for the core.
// Assumes the core takes o_req and returns i_ack/i_reti per service.
// Overview of operation
// - Every reset ends with the fetch address forced to 0000H.
// - Address latch and program store enables are weak high during reset.
// - Running reset never clears RAM; power-up contents are undefined.
// - Watchdog match resets internally without driving the reset pin.
// - Power-up sets power-on flag; only software clears it.
// - Boot: emulation if enabled, else autobaud up to 400 ms, then user; a baud lock in autobaud enters emulation.
// - Software reset only on a 0 to 1 change of the reset bit.
// - Software reset pulses SFR reset like any other reset; RAM is kept.
// - Brown-out acted on after four consecutive low samples.
// - Brown-out with interrupt disabled resets to 0000H.
// - Brown-out with interrupt enabled vectors to 004BH instead.
// - Core keeps running while enabled brown-out persists.
// - Clearing brown-out enable during active brown-out resets device.
// - Eight sources, each with one of four priority levels.
// - Equal levels served in fixed polling order, ext0 first.
// - Ext0 to 0003H, timer0 to 000BH, ext1 to 0013H.
// - Serial 0023H, timer1 001BH, timer2 002BH, counter array 0033H.
// - Global enable clear blocks all interrupt service.
`include "rip_regs.svh"
module rip_top #(
	parameter int unsigned AUTOBAUD_CYC = `RIP_AUTOBAUD_CYC,
	parameter int unsigned RST_MIN_CLKS = `RIP_RST_MIN_CLKS
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_power_up,
	input wire logic i_reset_pin,
	input wire logic i_wdt_match,
	input wire logic i_supply_low,
	input wire logic i_software_reset_bit,
	input wire logic i_emul_enabled,
	input wire logic i_baud_locked,
	input wire logic i_clear_power_on_flag,
	input wire logic i_brownout_irq_enable,
	input wire logic i_global_irq_enable,
	input wire rip_pkg::rip_irq_cfg_t i_cfg,
	input wire logic i_power_down,
	input wire logic i_ack,
	input wire logic i_reti,
	output logic o_core_reset,
	output logic o_sfr_reset,
	output logic o_ale_weak_high,
	output logic o_program_store_enable_out,
	output logic o_power_on_flag,
	output logic [15:0] o_fetch_addr,
	output logic o_fetch_load,
	output logic o_emul_mode,
	output logic o_baud_mode,
	output rip_pkg::rip_irq_req_t o_req,
	output logic o_wake
);
	import rip_pkg::*;

	localparam int NS = `RIP_NSRC;
	localparam logic [2:0] SRC_BOD = 3'h1;

	// Pin synchroniser: three stages, change when last two agree
	logic [2:0] pin_sync_q;
	logic pin_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pin_sync_q <= 3'h0;
			pin_q <= 1'b0;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], i_reset_pin};
			if (pin_sync_q[1] == pin_sync_q[2])
				pin_q <= pin_sync_q[2];
		end
	end

	logic [2:0] low_sync_q;
	logic low_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			low_sync_q <= 3'h0;
			low_q <= 1'b0;
		end else begin
			low_sync_q <= {low_sync_q[1:0], i_supply_low};
			if (low_sync_q[1] == low_sync_q[2])
				low_q <= low_sync_q[2];
		end
	end

	// Reset pin must stay high RST_MIN_CLKS before it counts
	logic [4:0] pin_cnt_q;
	logic pin_valid;
	always_ff @(posedge i_clk) begin
		if (i_rst || !pin_q)
			pin_cnt_q <= 5'h0;
		else if (pin_cnt_q != 5'(RST_MIN_CLKS))
			pin_cnt_q <= pin_cnt_q + 5'h1;
	end
	assign pin_valid = pin_q && (pin_cnt_q == 5'(RST_MIN_CLKS));

	// Brown-out filter
	logic [2:0] bod_cnt_q;
	logic bod_active;
	always_ff @(posedge i_clk) begin
		if (i_rst || !low_q)
			bod_cnt_q <= 3'h0;
		else if (bod_cnt_q != 3'(`RIP_BOD_FILT_CLKS))
			bod_cnt_q <= bod_cnt_q + 3'h1;
	end
	assign bod_active = (bod_cnt_q == 3'(`RIP_BOD_FILT_CLKS));

	// Software reset edge detect and brown-out enable history
	logic swr_prev_q;
	logic bod_en_prev_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			swr_prev_q <= 1'b0;
			bod_en_prev_q <= 1'b0;
		end else begin
			swr_prev_q <= i_software_reset_bit;
			bod_en_prev_q <= i_brownout_irq_enable;
		end
	end

	logic swr_rise;
	logic bod_reset;
	logic any_reset;
	assign swr_rise = i_software_reset_bit && !swr_prev_q;
	assign bod_reset = bod_active && (!i_brownout_irq_enable
		|| bod_en_prev_q);
	// Watchdog reset stays internal; pin is never driven
	assign any_reset = pin_valid || i_wdt_match || swr_rise
		|| (bod_reset && !i_brownout_irq_enable);

	// Core and SFR reset pulses; RAM has no reset term here
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_core_reset <= 1'b1;
			o_sfr_reset <= 1'b1;
		end else begin
			o_core_reset <= any_reset;
			// SFR reset pulses for every reset source, software reset included
			o_sfr_reset <= any_reset;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ale_weak_high <= 1'b1;
			o_program_store_enable_out <= 1'b1;
		end else begin
			o_ale_weak_high <= any_reset || pin_q;
			o_program_store_enable_out <= any_reset || pin_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_power_on_flag <= 1'b0;
		else if (i_power_up)
			o_power_on_flag <= 1'b1;
		else if (i_clear_power_on_flag)
			o_power_on_flag <= 1'b0;
	end

	// Boot path sequencer
	rip_boot_t boot_q;
	logic [31:0] baud_cnt_q;
	always_ff @(posedge i_clk) begin
		if (i_rst || any_reset) begin
			boot_q <= RIP_BOOT_RESET;
		end else begin
			case (boot_q)
			RIP_BOOT_RESET: begin
				if (i_emul_enabled)
					boot_q <= RIP_BOOT_EMUL;
				else
					boot_q <= RIP_BOOT_BAUD;
			end
			RIP_BOOT_BAUD: begin
				if (i_baud_locked)
					boot_q <= RIP_BOOT_EMUL;
				else if (baud_cnt_q >= AUTOBAUD_CYC - 1)
					boot_q <= RIP_BOOT_USER;
			end
			RIP_BOOT_EMUL: boot_q <= RIP_BOOT_EMUL;
			RIP_BOOT_USER: boot_q <= RIP_BOOT_USER;
			default: boot_q <= RIP_BOOT_RESET;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || boot_q != RIP_BOOT_BAUD)
			baud_cnt_q <= 32'h0;
		else
			baud_cnt_q <= baud_cnt_q + 32'h1;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_emul_mode <= 1'b0;
			o_baud_mode <= 1'b0;
		end else begin
			o_emul_mode <= (boot_q == RIP_BOOT_EMUL);
			o_baud_mode <= (boot_q == RIP_BOOT_BAUD);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_fetch_addr <= `RIP_RESET_VEC;
			o_fetch_load <= 1'b1;
		end else begin
			o_fetch_addr <= `RIP_RESET_VEC;
			o_fetch_load <= any_reset;
		end
	end

	// Interrupt arbitration
	logic [NS-1:0] pend;
	logic [1:0] lvl [NS];
	logic [15:0] vec [NS];
	assign vec[0] = `RIP_VEC_EXT0;
	assign vec[1] = `RIP_VEC_BOD;
	assign vec[2] = `RIP_VEC_TMR0;
	assign vec[3] = `RIP_VEC_EXT1;
	assign vec[4] = `RIP_VEC_TMR1;
	assign vec[5] = `RIP_VEC_CNTA;
	assign vec[6] = `RIP_VEC_SER;
	assign vec[7] = `RIP_VEC_TMR2;

	// Level per source from high and low bits, then pending mask
	always_comb begin
		for (int i = 0; i < NS; i++) begin
			lvl[i] = {i_cfg.prio_hi[i], i_cfg.prio_lo[i]};
			pend[i] = i_cfg.flag[i] && i_cfg.enable[i];
		end
		pend[SRC_BOD] = bod_active && i_brownout_irq_enable;
	end

	// Stack of levels in service, one bit per level
	logic [3:0] active_q;
	logic [2:0] top_lvl;
	logic any_active;
	always_comb begin
		top_lvl = 3'h0;
		any_active = |active_q;
		for (int l = 0; l < 4; l++)
			if (active_q[l])
				top_lvl = 3'(l);
	end

	rip_irq_req_t win;
	always_comb begin
		win = '0;
		for (int l = 3; l >= 0; l--) begin
			for (int i = NS - 1; i >= 0; i--) begin
				if (!win.valid || win.level == 2'(l))
					if (pend[i] && lvl[i] == 2'(l)) begin
						win.valid = 1'b1;
						win.src = 3'(i);
						win.level = 2'(l);
						win.vector = vec[i];
					end
			end
			if (win.valid)
				break;
		end
		if (any_active && {1'b0, win.level} <= top_lvl)
			win.valid = 1'b0;
		if (!i_global_irq_enable || any_reset)
			win.valid = 1'b0;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || any_reset)
			o_req <= '0;
		else
			o_req <= win;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || any_reset) begin
			active_q <= 4'h0;
		end else if (i_ack && o_req.valid) begin
			active_q[o_req.level] <= 1'b1;
		end else if (i_reti && any_active) begin
			active_q[top_lvl[1:0]] <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_wake <= 1'b0;
		else
			o_wake <= i_power_down && (pend[0] || pend[3]);
	end

	// Enable dropped while the filtered brown-out still stands
	sequence s_enable_drop;
		bod_active && $fell(i_brownout_irq_enable);
	endsequence

	// Core reset, SFR reset and fetch load all high in one cycle
	sequence s_reset_out;
		o_core_reset && o_sfr_reset && o_fetch_load;
	endsequence

	a_bod_filter: assert property (
		@(posedge i_clk) disable iff (i_rst)
		bod_active |-> $past(low_q, 4))
		else $error("brown-out acted on too early");
	a_swr_edge: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(i_software_reset_bit && swr_prev_q && !pin_valid && !i_wdt_match
		&& !bod_active) |=> !o_core_reset)
		else $error("software reset without rising edge");
	a_reset_vector: assert property (
		@(posedge i_clk) disable iff (i_rst)
		any_reset |=> o_fetch_load && o_fetch_addr == 16'h0000)
		else $error("reset did not load 0000H");
	a_global_gate: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!i_global_irq_enable |=> !o_req.valid)
		else $error("request with global enable clear");
	a_bod_vector: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_req.valid && o_req.src == SRC_BOD |-> o_req.vector == 16'h004b)
		else $error("brown-out vector wrong");
	a_bod_en_clear: assert property (
		@(posedge i_clk) disable iff (i_rst)
		s_enable_drop |=> s_reset_out)
		else $error("clearing enable in brown-out did not reset");
	a_wake_ext: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_wake |-> $past(pend[0] || pend[3]))
		else $error("wake from non-external source");
	a_pin_min: assert property (
		@(posedge i_clk) disable iff (i_rst)
		$rose(pin_valid) |-> $past(pin_q, 8))
		else $error("reset pin accepted too short");
	a_ext0_vec: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_req.valid && o_req.src == 3'h0 |-> o_req.vector == 16'h0003)
		else $error("ext0 vector wrong");
	a_wdt_reset: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_wdt_match |=> s_reset_out)
		else $error("watchdog match did not reset");
	a_pse_reset: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_core_reset |-> o_program_store_enable_out && o_ale_weak_high)
		else $error("enables not high during reset");
endmodule

// File: test_rip_top.sv
// Self-checking bench for the reset and interrupt priority block.
// Assumes rip_core_model answers the interrupt handshake.
module test_rip_top import rip_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, pwr, pin, wdt, low, software_reset_bit, emul, clr, boe, gie, pd;
	logic ack, reti, accept, ret_cmd, core_rst, ale, pse, power_on_flag, emu, baud;
	logic wake, sfr, fld;
	logic [15:0] faddr, taken, vec;
	logic [4:0] seen;
	rip_irq_cfg_t cfg;
	rip_irq_req_t req;
	int err_count, check_count;
	localparam logic [15:0] VEC [8] = '{16'h0003, 16'h004b, 16'h000b,
		16'h0013, 16'h001b, 16'h0033, 16'h0023, 16'h002b};
	rip_top #(.AUTOBAUD_CYC(50), .RST_MIN_CLKS(24)) i_rip_top (
		.i_clk(clk), .i_rst(rst), .i_power_up(pwr), .i_reset_pin(pin),
		.i_wdt_match(wdt), .i_supply_low(low), .i_software_reset_bit(software_reset_bit),
		.i_emul_enabled(emul), .i_baud_locked(1'b0),
		.i_clear_power_on_flag(clr), .i_brownout_irq_enable(boe),
		.i_global_irq_enable(gie), .i_cfg(cfg), .i_power_down(pd),
		.i_ack(ack), .i_reti(reti), .o_core_reset(core_rst),
		.o_sfr_reset(sfr), .o_ale_weak_high(ale),
		.o_program_store_enable_out(pse), .o_power_on_flag(power_on_flag),
		.o_fetch_addr(faddr), .o_fetch_load(fld), .o_emul_mode(emu),
		.o_baud_mode(baud), .o_req(req), .o_wake(wake));
	rip_core_model i_rip_core_model (.i_clk(clk), .i_accept(accept),
		.i_ret_cmd(ret_cmd), .i_req(req), .o_ack(ack), .o_reti(reti),
		.o_taken_vec(taken));
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Gathers what the outputs showed over n falling edges
	task automatic watch(input int n);
		seen = '0;
		vec = 16'hffff;
		repeat (n) begin
			@(negedge clk);
			seen = seen | {core_rst, wake, emu, baud, req.valid};
			if (req.valid === 1'b1 && vec === 16'hffff)
				vec = req.vector;
		end
	endtask
	task automatic end_sim;
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{pwr, pin, wdt, low, software_reset_bit, emul, clr, boe, gie, pd} = '0;
		{accept, ret_cmd, err_count, check_count} = '0;
		cfg = '0;
		rst = 1'b1;
		watch(4);
		chk({ale, pse, faddr}, {2'b11, 16'h0000});
		chk({sfr, fld, core_rst}, 3'b111);
		watch(1);
		for (int e = 1; e >= 0; e--) begin
			emul = e[0];
			rst = 1'b1;
			watch(2);
			rst = 1'b0;
			watch(20);
			chk(seen[2:1], {e[0], ~e[0]});
		end
		watch(100);
		chk(baud, 1'b0);
		pwr = 1'b1;
		watch(1);
		pwr = 1'b0;
		watch(10);
		chk(power_on_flag, 1'b1);
		clr = 1'b1;
		watch(1);
		clr = 1'b0;
		watch(2);
		chk(power_on_flag, 1'b0);
		// Pin held short of the minimum, then long enough
		pin = 1'b1;
		watch(12);
		pin = 1'b0;
		chk(seen[4], 1'b0);
		watch(5);
		pin = 1'b1;
		watch(40);
		chk({seen[4], ale, pse}, 3'b111);
		pin = 1'b0;
		watch(8);
		wdt = 1'b1;
		watch(1);
		wdt = 1'b0;
		chk({seen[4], sfr, fld, faddr}, {3'b111, 16'h0000});
		watch(8);
		chk({seen[4], sfr, fld}, 3'b000);
		software_reset_bit = 1'b1;
		watch(8);
		chk(seen[4], 1'b1);
		watch(10);
		chk(seen[4], 1'b0);
		// Brown-out glitch of three clocks must be filtered out
		low = 1'b1;
		watch(3);
		low = 1'b0;
		watch(12);
		chk(seen[4], 1'b0);
		low = 1'b1;
		watch(15);
		chk(seen[4], 1'b1);
		low = 1'b0;
		watch(10);
		gie = 1'b1;
		boe = 1'b1;
		low = 1'b1;
		watch(15);
		chk({seen[4], vec}, {1'b0, 16'h004b});
		boe = 1'b0;
		watch(6);
		chk(seen[4], 1'b1);
		low = 1'b0;
		watch(10);
		// All sources but brown-out from index i up pending at one level
		cfg.enable = 8'hff;
		for (int i = 0; i < 8; i++) begin
			if (i != 1) begin
				cfg.flag = 8'hfd & ~((8'h01 << i) - 8'h01);
				watch(5);
				chk(vec, VEC[i]);
				cfg.flag = '0;
				watch(3);
			end
		end
		gie = 1'b0;
		cfg.flag = 8'hfd;
		watch(10);
		chk(seen[0], 1'b0);
		gie = 1'b1;
		pd = 1'b1;
		cfg.flag = 8'h04;
		watch(6);
		chk(seen[3], 1'b0);
		cfg.flag = 8'h08;
		watch(6);
		chk(seen[3], 1'b1);
		pd = 1'b0;
		cfg.flag = '0;
		watch(3);
		// Timer 2 at level 3 against timer 1 at level 1
		cfg.prio_hi = 8'h80;
		cfg.prio_lo = 8'h90;
		cfg.flag = 8'h90;
		watch(5);
		chk(vec, 16'h002b);
		accept = 1'b1;
		watch(6);
		accept = 1'b0;
		chk(taken, 16'h002b);
		cfg.flag = 8'h10;
		watch(10);
		chk(seen[0], 1'b0);
		ret_cmd = 1'b1;
		watch(1);
		ret_cmd = 1'b0;
		watch(6);
		chk(vec, 16'h001b);
		accept = 1'b1;
		watch(6);
		accept = 1'b0;
		cfg.flag = 8'h90;
		watch(6);
		chk(vec, 16'h002b);
		end_sim();
	end
endmodule
